//--- design/repeat_reset_link_test_fsm.sv
// How it works
// - Idle holds pass, fail zero; iteration count clears once run drops.
// - Start enters assert; init reset timed high.
// - Release reset, preload check timer from select.
// - Three-bit select picks channel-up wait time.
// - Wait until timer expires, watching errors.
// - Pass needs link up, at most one toggle.
// - Failed check stops run; else traffic wait.
// - Traffic wait lets packets flow, then check.
// - Check toggles again; repeat until count reached.
// - Four-bit select maps to iteration count.
// - Pass flag after all iterations succeed.
// - Fail on missing link up or data error.
// - Count link-up toggles; expose bits 15:8.
// - Count link reset assertions, readable.
// - Data error count healthy only at zero.
// - Sequencer reset returns to idle independently.
// - Counter clear leaves link untouched.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "reset_test_consts.svh"

module repeat_reset_link_test_fsm #(
	parameter reset_test_pkg::timer_t ASSERT_CYCLES = `ASSERT_CYCLES_DEF,
	parameter reset_test_pkg::timer_t CHECK_BASE    = `CHECK_BASE_DEF,
	parameter reset_test_pkg::timer_t TRAFFIC_CYCLES = `TRAFFIC_DEF
) (
	input  wire logic        i_ref_clk,        // 50 MHz clock.
	input  wire logic        i_rstn,           // Async reset, low.
	input  wire logic        i_link_up,        // Channel up from link.
	input  wire logic        i_link_reset,     // Link reset indication.
	input  wire logic        i_soft_err,       // Soft error level.
	input  wire logic [7:0]  i_data_err_count, // Received data errors.
	output logic             o_init_reset,     // Link init reset drive.
	output logic             o_test_passed,    // Run passed.
	output logic             o_test_failed,    // Run failed.
	input  wire logic [7:0]  i_s_axi_awaddr,   // Write address.
	input  wire logic        i_s_axi_awvalid,  // Write address valid.
	output logic             o_s_axi_awready,  // Write address ready.
	input  wire logic [31:0] i_s_axi_wdata,    // Write data.
	input  wire logic [3:0]  i_s_axi_wstrb,    // Write strobes.
	input  wire logic        i_s_axi_wvalid,   // Write data valid.
	output logic             o_s_axi_wready,   // Write data ready.
	output logic [1:0]       o_s_axi_bresp,    // Write response.
	output logic             o_s_axi_bvalid,   // Write response valid.
	input  wire logic        i_s_axi_bready,   // Write response ready.
	input  wire logic [7:0]  i_s_axi_araddr,   // Read address.
	input  wire logic        i_s_axi_arvalid,  // Read address valid.
	output logic             o_s_axi_arready,  // Read address ready.
	output logic [31:0]      o_s_axi_rdata,    // Read data.
	output logic [1:0]       o_s_axi_rresp,    // Read response.
	output logic             o_s_axi_rvalid,   // Read data valid.
	input  wire logic        i_s_axi_rready    // Read data ready.
);
	import reset_test_pkg::*;

	// =============================================================
	// Helper functions.

	// Check time doubles with each select step above the base.
	function automatic timer_t check_time(input logic [2:0] sel);
		check_time = timer_t'(CHECK_BASE << sel);
	endfunction

	// Each iteration select maps to a power of two iterations.
	function automatic logic [15:0] iter_target(input logic [3:0] sel);
		iter_target = 16'(`ITER_ONE << sel);
	endfunction

	// Wrapping increment shared by all quality counters.
	function automatic count20_t inc20(input count20_t v);
		inc20 = 20'(v + `CNT20_ONE);
	endfunction

	// =============================================================
	// Declarations.
	test_state_e state_reg;
	timer_t      timer_reg;
	logic [15:0] iter_reg;
	logic [3:0]  toggle_reg;
	logic        soft_seen_reg;
	logic        link_up_d_reg;
	logic        link_rst_d_reg;
	logic        soft_d_reg;
	count20_t    linkup_cnt_reg;
	count20_t    linkrst_cnt_reg;
	count20_t    softerr_cnt_reg;
	logic        run_reg;
	logic        fsm_rst_reg;
	logic        clear_reg;
	logic [7:0]  config_reg;
	logic        pass_reg;
	logic        fail_reg;
	logic        init_rst_reg;
	logic [3:0]  sync_in;
	logic [3:0]  sync_out;
	logic        link_up_s;
	logic        link_rst_s;
	logic        soft_s;
	logic        data_err_s;
	logic        link_up_edge;
	logic        link_rst_rise;
	logic        soft_rise;
	logic        wait_ok;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;
	logic        wr_hit;
	logic [31:0] rd_value;
	logic        rd_hit;

	// =============================================================
	// Pin synchronisers.

	// The data error test is reduced to one level before crossing,
	// so no multi-bit value is sampled mid-change.
	assign sync_in = {(i_data_err_count != 8'h00), i_soft_err,
		i_link_reset, i_link_up};

	sync2 #(
		.W (4)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_async   (sync_in),
		.o_sync    (sync_out)
	);

	assign link_up_s  = sync_out[0];
	assign link_rst_s = sync_out[1];
	assign soft_s     = sync_out[2];
	assign data_err_s = sync_out[3];

	// Edge detection runs on the synchronised copies only.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			link_up_d_reg  <= 1'b0;
			link_rst_d_reg <= 1'b0;
			soft_d_reg     <= 1'b0;
		end else begin
			link_up_d_reg  <= link_up_s;
			link_rst_d_reg <= link_rst_s;
			soft_d_reg     <= soft_s;
		end
	end

	assign link_up_edge  = link_up_s ^ link_up_d_reg;
	assign link_rst_rise = link_rst_s & ~link_rst_d_reg;
	assign soft_rise     = soft_s & ~soft_d_reg;

	// The channel must be up, bounce at most once and stay clean.
	assign wait_ok = link_up_s && (toggle_reg <= `MAX_TOGGLES) &&
		!data_err_s && !soft_seen_reg;

	// =============================================================
	// Test sequencer.

	// The sequencer reset is a synchronous pulse from software; it clears
	// the iteration count and leaves the bus and the quality counters alone.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= idle_state;
			timer_reg <= '0;
		end else if (fsm_rst_reg) begin
			state_reg <= idle_state;
			timer_reg <= '0;
		end else begin
			case (state_reg)
			idle_state: begin
				if (run_reg) begin
					state_reg <= reset_assert_state;
					timer_reg <= timer_t'(ASSERT_CYCLES - 1'b1);
				end
			end
			reset_assert_state: begin
				if (timer_reg == '0) begin
					state_reg <= reset_release_state;
				end else begin
					timer_reg <= timer_t'(timer_reg - 1'b1);
				end
			end
			reset_release_state: begin
				state_reg <= check_wait_state;
				timer_reg <= check_time(config_reg[`CFG_CHK_MSB:
					`CFG_CHK_LSB]);
			end
			check_wait_state: begin
				if (timer_reg != '0) begin
					timer_reg <= timer_t'(timer_reg - 1'b1);
				end else if (wait_ok) begin
					state_reg <= traffic_wait_state;
					timer_reg <= timer_t'(TRAFFIC_CYCLES - 1'b1);
				end else begin
					state_reg <= fail_state;
				end
			end
			traffic_wait_state: begin
				if (data_err_s) begin
					state_reg <= fail_state;
				end else if (timer_reg == '0) begin
					state_reg <= check_state;
				end else begin
					timer_reg <= timer_t'(timer_reg - 1'b1);
				end
			end
			check_state: begin
				if (toggle_reg > `MAX_TOGGLES || data_err_s) begin
					state_reg <= fail_state;
				end else if (16'(iter_reg + 1'b1) >= iter_target(
					config_reg[`CFG_ITER_MSB:`CFG_ITER_LSB])) begin
					state_reg <= done_state;
				end else begin
					state_reg <= idle_state;
				end
			end
			done_state: begin
				if (!run_reg) begin
					state_reg <= idle_state;
				end
			end
			fail_state: begin
				state_reg <= fail_state;
			end
			default: begin
				state_reg <= idle_state;
			end
			endcase
		end
	end

	// Iteration count survives the return to idle between passes
	// and clears once the run is dropped.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			iter_reg <= '0;
		end else if (fsm_rst_reg) begin
			iter_reg <= '0;
		end else if (state_reg == idle_state && !run_reg) begin
			iter_reg <= '0;
		end else if (state_reg == check_state &&
			toggle_reg <= `MAX_TOGGLES && !data_err_s) begin
			iter_reg <= 16'(iter_reg + 1'b1);
		end
	end

	// Per-pulse toggle and soft error tracking, cleared each assert.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			toggle_reg    <= '0;
			soft_seen_reg <= 1'b0;
		end else if (state_reg == reset_assert_state) begin
			toggle_reg    <= '0;
			soft_seen_reg <= 1'b0;
		end else begin
			if (link_up_edge && toggle_reg != `TOGGLE_SAT) begin
				toggle_reg <= 4'(toggle_reg + 1'b1);
			end
			if (soft_s && state_reg == check_wait_state) begin
				soft_seen_reg <= 1'b1;
			end
		end
	end

	// Status outputs lag the state by one cycle and are glitch free.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pass_reg     <= 1'b0;
			fail_reg     <= 1'b0;
			init_rst_reg <= 1'b0;
		end else begin
			pass_reg     <= (state_reg == done_state);
			fail_reg     <= (state_reg == fail_state);
			init_rst_reg <= (state_reg == reset_assert_state);
		end
	end

	assign o_test_passed = pass_reg;
	assign o_test_failed = fail_reg;
	assign o_init_reset  = init_rst_reg;

	// =============================================================
	// Link quality counters.

	// An event in the clearing cycle is kept: it counts as one.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			linkup_cnt_reg  <= '0;
			linkrst_cnt_reg <= '0;
			softerr_cnt_reg <= '0;
		end else begin
			if (clear_reg) begin
				linkup_cnt_reg <= link_up_edge ? `CNT20_ONE : '0;
			end else if (link_up_edge) begin
				linkup_cnt_reg <= inc20(linkup_cnt_reg);
			end
			if (clear_reg) begin
				linkrst_cnt_reg <= link_rst_rise ? `CNT20_ONE : '0;
			end else if (link_rst_rise) begin
				linkrst_cnt_reg <= inc20(linkrst_cnt_reg);
			end
			if (clear_reg) begin
				softerr_cnt_reg <= soft_rise ? `CNT20_ONE : '0;
			end else if (soft_rise) begin
				softerr_cnt_reg <= inc20(softerr_cnt_reg);
			end
		end
	end

	// =============================================================
	// AXI4-Lite write path.

	// Address and data are held separately so either may come first.
	assign o_s_axi_awready = !aw_held_reg && !o_s_axi_bvalid;
	assign o_s_axi_wready  = !w_held_reg && !o_s_axi_bvalid;
	assign wr_fire = aw_held_reg && w_held_reg;
	assign wr_hit  = (aw_addr_reg == `OFF_CONTROL) ||
		(aw_addr_reg == `OFF_CONFIG) || (aw_addr_reg == `OFF_STATUS) ||
		(aw_addr_reg == `OFF_ITERATION) ||
		(aw_addr_reg == `OFF_LINKUP_CNT) ||
		(aw_addr_reg == `OFF_LINKRST_CNT) ||
		(aw_addr_reg == `OFF_SOFTERR_CNT);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			aw_held_reg    <= 1'b0;
			w_held_reg     <= 1'b0;
			aw_addr_reg    <= '0;
			w_data_reg     <= '0;
			w_strb_reg     <= '0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= i_s_axi_wdata;
				w_strb_reg <= i_s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg    <= 1'b0;
				w_held_reg     <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control bits: run is a level, the other two are one-cycle.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_reg     <= 1'b0;
			fsm_rst_reg <= 1'b0;
			clear_reg   <= 1'b0;
			config_reg  <= `CONFIG_RESET;
		end else begin
			fsm_rst_reg <= 1'b0;
			clear_reg   <= 1'b0;
			if (wr_fire && w_strb_reg[0]) begin
				if (aw_addr_reg == `OFF_CONTROL) begin
					run_reg     <= w_data_reg[`CTL_RUN_BIT];
					fsm_rst_reg <= w_data_reg[`CTL_FSMRST_BIT];
					clear_reg   <= w_data_reg[`CTL_CLEAR_BIT];
				end
				if (aw_addr_reg == `OFF_CONFIG) begin
					config_reg <= w_data_reg[7:0];
				end
			end
		end
	end

	// =============================================================
	// AXI4-Lite read path.

	always_comb begin
		rd_value = '0;
		rd_hit   = 1'b1;
		case (i_s_axi_araddr)
		`OFF_CONTROL: begin
			rd_value[`CTL_RUN_BIT] = run_reg;
		end
		`OFF_CONFIG: begin
			rd_value[7:0] = config_reg;
		end
		`OFF_STATUS: begin
			rd_value[`STS_PASS_BIT]    = pass_reg;
			rd_value[`STS_FAIL_BIT]    = fail_reg;
			rd_value[`STS_STATE_MSB:`STS_STATE_LSB] = state_reg;
			rd_value[`STS_INITRST_BIT] = init_rst_reg;
			rd_value[`STS_LINKUP_BIT]  = link_up_s;
		end
		`OFF_ITERATION: begin
			rd_value[15:0] = iter_reg;
		end
		`OFF_LINKUP_CNT: begin
			rd_value[7:0] = linkup_cnt_reg[15:8];
		end
		`OFF_LINKRST_CNT: begin
			rd_value[19:0] = linkrst_cnt_reg;
		end
		`OFF_SOFTERR_CNT: begin
			rd_value[19:0] = softerr_cnt_reg;
		end
		default: begin
			rd_hit = 1'b0;
		end
		endcase
	end

	assign o_s_axi_arready = !o_s_axi_rvalid;

	// Read data is captured at the address handshake and held.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= '0;
			o_s_axi_rresp  <= `RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rdata  <= rd_value;
			o_s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end

endmodule

//--- design/reset_test_consts.svh
`ifndef RESET_TEST_CONSTS_SVH
`define RESET_TEST_CONSTS_SVH

// =============================================================
// Register byte offsets on the AXI4-Lite slave.
`define OFF_CONTROL       8'h00
`define OFF_CONFIG        8'h04
`define OFF_STATUS        8'h08
`define OFF_ITERATION     8'h0C
`define OFF_LINKUP_CNT    8'h10
`define OFF_LINKRST_CNT   8'h14
`define OFF_SOFTERR_CNT   8'h18

// =============================================================
// Field positions.
`define CTL_RUN_BIT       0
`define CTL_FSMRST_BIT    1
`define CTL_CLEAR_BIT     2
`define CFG_CHK_LSB       0
`define CFG_CHK_MSB       2
`define CFG_ITER_LSB      4
`define CFG_ITER_MSB      7
`define STS_PASS_BIT      0
`define STS_FAIL_BIT      1
`define STS_STATE_LSB     4
`define STS_STATE_MSB     6
`define STS_INITRST_BIT   8
`define STS_LINKUP_BIT    9

// =============================================================
// Reset values, responses and timing defaults in clock cycles.
`define CONFIG_RESET      8'h00
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define ASSERT_CYCLES_DEF 28'hFFFFFFF
`define CHECK_BASE_DEF    28'h0100000
`define TRAFFIC_DEF       28'h0010000
`define MAX_TOGGLES       4'h1
`define TOGGLE_SAT        4'hF
`define ITER_ONE          16'h0001
`define CNT20_ONE         20'h00001

`endif

//--- design/reset_test_pkg.sv
package reset_test_pkg;

	// =============================================================
	// States of the repeat reset test sequencer.
	typedef enum logic [2:0] {
		idle_state          = 3'b000,
		reset_assert_state  = 3'b001,
		reset_release_state = 3'b010,
		check_wait_state    = 3'b011,
		traffic_wait_state  = 3'b100,
		check_state         = 3'b101,
		fail_state          = 3'b110,
		done_state          = 3'b111
	} test_state_e;

	typedef logic [27:0] timer_t;
	typedef logic [19:0] count20_t;

endpackage

//--- design/sync2.sv
`timescale 1ns/1ps

// =============================================================
// Two flip-flop level synchroniser for pins from the link clock.
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_ref_clk, // Local clock.
	input  wire logic         i_rstn,    // Asynchronous reset, low.
	input  wire logic [W-1:0] i_async,   // Levels from another domain.
	output logic      [W-1:0] o_sync     // Synchronised levels.
);

	logic [W-1:0] meta_reg;

	// The first stage feeds only the second one.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end

endmodule

//--- testbench/link_partner.sv
`timescale 1ns/1ps

// =============================================================
// Link core model: channel drops during init reset, trains after.
module link_partner (
	input  wire logic       i_ref_clk, // Clock.
	input  wire logic       i_rstn,    // Async reset, low.
	input  wire logic       i_init,    // Init reset from tester.
	input  wire logic [2:0] i_mode,    // Fault to show, 0 none.
	output logic            o_up,      // Channel up.
	output logic            o_lrst,    // Link reset indication.
	output logic            o_soft,    // Soft error.
	output logic [7:0]      o_derr     // Data error count.
);
	logic [4:0] age_reg;

	// Cycles since release; it saturates so a good link stays up.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			age_reg <= 5'h00;
		else if (i_init)
			age_reg <= 5'h00;
		else if (age_reg != 5'h1F)
			age_reg <= age_reg + 5'h01;
	end

	// Mode 1 flaps, 2 data errors, 3 one soft error, 4 never up.
	always_comb begin
		o_lrst = i_init;
		o_up = !i_init && i_mode != 3'h4 && age_reg >= 5'h02 &&
			!(i_mode == 3'h1 && age_reg == 5'h04);
		o_soft = i_mode == 3'h3 && age_reg == 5'h08;
		o_derr = (i_mode == 3'h2 && age_reg >= 5'h0C) ? 8'h01 : 8'h00;
	end
endmodule

//--- testbench/link_test_chk.sv
`timescale 1ns/1ps

// =============================================================
// Port checker for the repeat reset tester.
module link_test_chk #(
	parameter reset_test_pkg::timer_t ASSERT_CYCLES = 28'h0000008
) (
	input  wire logic i_ref_clk,       // Clock.
	input  wire logic i_rstn,          // Async reset, low.
	input  wire logic o_init_reset,    // Init reset drive.
	input  wire logic o_test_passed,   // Pass flag.
	input  wire logic o_test_failed,   // Fail flag.
	input  wire logic i_s_axi_awvalid, // Write address valid.
	input  wire logic o_s_axi_awready, // Write address ready.
	input  wire logic i_s_axi_wvalid,  // Write data valid.
	input  wire logic o_s_axi_wready,  // Write data ready.
	input  wire logic o_s_axi_bvalid,  // Write response valid.
	input  wire logic o_s_axi_arready, // Read address ready.
	input  wire logic o_s_axi_rvalid   // Read data valid.
);
	import reset_test_pkg::*;

	timer_t high_reg;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	// Length of the running init pulse; a stuck timer shows here.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			high_reg <= 28'h0000000;
		else if (o_init_reset)
			high_reg <= high_reg + 28'h0000001;
		else
			high_reg <= 28'h0000000;
	end

	// =============================================================
	// Sequences and properties.
	sequence s_released;
		$fell(o_init_reset);
	endsequence
	sequence s_quiet8;
		(!o_init_reset)[*8];
	endsequence
	// Flags may only drop shortly after a control write answered.
	sequence s_recent_write;
		$past(o_s_axi_bvalid, 1) || $past(o_s_axi_bvalid, 2) ||
			$past(o_s_axi_bvalid, 3);
	endsequence
	property p_assert_len;
		s_released |-> high_reg == ASSERT_CYCLES;
	endproperty
	property p_release_quiet;
		s_released |-> s_quiet8;
	endproperty
	property p_fail_quiet;
		o_test_failed |-> !o_init_reset && !o_test_passed;
	endproperty
	property p_fail_hold;
		$fell(o_test_failed) |-> s_recent_write;
	endproperty
	property p_pass_hold;
		$fell(o_test_passed) |-> s_recent_write;
	endproperty
	property p_pass_quiet;
		o_test_passed |-> !o_init_reset;
	endproperty
	property p_b_busy;
		o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
	endproperty
	property p_r_busy;
		o_s_axi_rvalid |-> !o_s_axi_arready;
	endproperty
	// The response is seen two edges after the later handshake.
	property p_b_cause;
		$rose(o_s_axi_bvalid) |->
			$past(i_s_axi_awvalid && o_s_axi_awready, 2) ||
			$past(i_s_axi_wvalid && o_s_axi_wready, 2);
	endproperty

	// =============================================================
	// Assertions.
	a_assert_len: assert property (p_assert_len)
		else $error("init reset pulse has the wrong length");
	a_release_quiet: assert property (p_release_quiet)
		else $error("init reset came back too soon");
	a_fail_quiet: assert property (p_fail_quiet)
		else $error("fail state drives init reset or pass");
	a_fail_hold: assert property (p_fail_hold)
		else $error("fail flag dropped without a control write");
	a_pass_hold: assert property (p_pass_hold)
		else $error("pass flag dropped without a control write");
	a_pass_quiet: assert property (p_pass_quiet)
		else $error("pass flag high while init reset driven");
	a_b_busy: assert property (p_b_busy)
		else $error("write ready while response pending");
	a_r_busy: assert property (p_r_busy)
		else $error("read ready while data pending");
	a_b_cause: assert property (p_b_cause)
		else $error("write response without a handshake");
endmodule

bind repeat_reset_link_test_fsm link_test_chk #(
	.ASSERT_CYCLES(ASSERT_CYCLES)
) link_test_chk_i (.i_ref_clk, .i_rstn, .o_init_reset, .o_test_passed,
	.o_test_failed, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
	.o_s_axi_wready, .o_s_axi_bvalid, .o_s_axi_arready, .o_s_axi_rvalid);

//--- testbench/tb_repeat_reset_link_test_fsm.sv
`timescale 1ns/1ps
`include "reset_test_consts.svh"

module tb_repeat_reset_link_test_fsm;
	import reset_test_pkg::*;

	logic        i_ref_clk, i_rstn, i_link_up, i_link_reset, i_soft_err;
	logic [7:0]  i_data_err_count, i_s_axi_awaddr, i_s_axi_araddr;
	logic        o_init_reset, o_test_passed, o_test_failed;
	logic        i_s_axi_awvalid, o_s_axi_awready;
	logic        i_s_axi_wvalid, o_s_axi_wready;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd_data;
	logic [3:0]  i_s_axi_wstrb;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rd_resp;
	logic        o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid;
	logic        o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready;
	logic [2:0]  mode;
	int          errors, comparisons, cycles;

	// Short counts keep each iteration to a few dozen cycles.
	repeat_reset_link_test_fsm #(
		.ASSERT_CYCLES(28'h0000008),
		.CHECK_BASE(28'h0000004),
		.TRAFFIC_CYCLES(28'h0000008)
	) repeat_reset_link_test_fsm_i (.i_ref_clk, .i_rstn, .i_link_up,
		.i_link_reset, .i_soft_err, .i_data_err_count, .o_init_reset,
		.o_test_passed, .o_test_failed, .i_s_axi_awaddr, .i_s_axi_awvalid,
		.o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
		.o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
		.i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
		.o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready);

	link_partner link_partner_i (.i_ref_clk, .i_rstn, .i_init(o_init_reset),
		.i_mode(mode), .o_up(i_link_up), .o_lrst(i_link_reset),
		.o_soft(i_soft_err), .o_derr(i_data_err_count));

	// =============================================================
	// Helpers.
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task end_sim;
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Write one word; each channel is released at its own handshake.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, done;
		logic [1:0] r;
		int n;
		done = 1'b0;
		n = 0;
		@(posedge i_ref_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		while (!done && n < 100) begin
			@(negedge i_ref_clk);
			ta = i_s_axi_awvalid && o_s_axi_awready;
			tw = i_s_axi_wvalid && o_s_axi_wready;
			done = o_s_axi_bvalid;
			r = o_s_axi_bresp;
			@(posedge i_ref_clk);
			if (ta)
				i_s_axi_awvalid <= 1'b0;
			if (tw)
				i_s_axi_wvalid <= 1'b0;
			if (done)
				i_s_axi_bready <= 1'b0;
			n++;
		end
		if (!done)
			errors++;
		chk({30'h0, r}, {30'h0, er});
	endtask

	// Read one word, then compare the masked data and the response.
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		logic ta, done;
		int n;
		done = 1'b0;
		n = 0;
		@(posedge i_ref_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		while (!done && n < 100) begin
			@(negedge i_ref_clk);
			ta = i_s_axi_arvalid && o_s_axi_arready;
			done = o_s_axi_rvalid;
			rd_data = o_s_axi_rdata;
			rd_resp = o_s_axi_rresp;
			@(posedge i_ref_clk);
			if (ta)
				i_s_axi_arvalid <= 1'b0;
			if (done)
				i_s_axi_rready <= 1'b0;
			n++;
		end
		if (!done)
			errors++;
		chk(rd_data & m, e);
		chk({30'h0, rd_resp}, {30'h0, er});
	endtask

	// Count cycles until either verdict flag rises.
	task wait_end;
		cycles = 0;
		@(negedge i_ref_clk);
		while (!(o_test_passed === 1'b1 || o_test_failed === 1'b1) &&
			cycles < 5000) begin
			@(negedge i_ref_clk);
			cycles++;
		end
		@(posedge i_ref_clk);
	endtask

	// =============================================================
	// Scenarios.
	task t_reset;
		rc(`OFF_CONFIG, 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
		rc(`OFF_STATUS, 32'h00000073, 32'h0, `RESP_OKAY);
		rc(`OFF_ITERATION, 32'h0000FFFF, 32'h0, `RESP_OKAY);
		rc(8'h1C, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
		wr(8'h1C, 32'h00000001, `RESP_SLVERR);
		i_s_axi_wstrb <= 4'hE;
		wr(`OFF_CONFIG, 32'h000000FF, `RESP_OKAY);
		i_s_axi_wstrb <= 4'hF;
		rc(`OFF_CONFIG, 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
	endtask

	task t_pass;
		wr(`OFF_CONFIG, 32'h00000012, `RESP_OKAY);
		wr(`OFF_CONTROL, 32'h00000001, `RESP_OKAY);
		wait_end;
		chk({31'h0, o_test_passed}, 32'h1);
		rc(`OFF_ITERATION, 32'h0000FFFF, 32'h2, `RESP_OKAY);
		rc(`OFF_LINKRST_CNT, 32'h000FFFFF, 32'h2, `RESP_OKAY);
		rc(`OFF_STATUS, 32'h00000073, 32'h71, `RESP_OKAY);
		chk({31'h0, o_test_passed}, 32'h1);
		wr(`OFF_CONTROL, 32'h0, `RESP_OKAY);
		rc(`OFF_ITERATION, 32'h0000FFFF, 32'h0, `RESP_OKAY);
		chk({31'h0, o_test_passed}, 32'h0);
	endtask

	// One failing run with the given fault, time window and select.
	task t_fail(input logic [2:0] m, input logic [31:0] cfg, input int lo,
		input int hi);
		mode <= m;
		wr(`OFF_CONFIG, cfg, `RESP_OKAY);
		wr(`OFF_CONTROL, 32'h00000001, `RESP_OKAY);
		wait_end;
		chk({31'h0, o_test_failed}, 32'h1);
		chk({31'h0, cycles >= lo && cycles <= hi}, 32'h1);
		wr(`OFF_CONTROL, 32'h00000001, `RESP_OKAY);
		rc(`OFF_STATUS, 32'h00000173, 32'h62, `RESP_OKAY);
		wr(`OFF_CONTROL, 32'h00000002, `RESP_OKAY);
		rc(`OFF_STATUS, 32'h00000073, 32'h0, `RESP_OKAY);
		mode <= 3'h0;
	endtask

	task t_clear;
		rc(`OFF_SOFTERR_CNT, 32'h000FFFFF, 32'h1, `RESP_OKAY);
		wr(`OFF_CONTROL, 32'h00000004, `RESP_OKAY);
		rc(`OFF_LINKRST_CNT, 32'h000FFFFF, 32'h0, `RESP_OKAY);
		rc(`OFF_SOFTERR_CNT, 32'h000FFFFF, 32'h0, `RESP_OKAY);
		rc(`OFF_LINKUP_CNT, 32'h000000FF, 32'h0, `RESP_OKAY);
		rc(`OFF_STATUS, 32'h00000373, 32'h200, `RESP_OKAY);
		wr(`OFF_CONFIG, 32'h00000071, `RESP_OKAY);
		wr(`OFF_CONTROL, 32'h00000001, `RESP_OKAY);
		wait_end;
		chk({31'h0, o_test_passed}, 32'h1);
		rc(`OFF_ITERATION, 32'h0000FFFF, 32'h80, `RESP_OKAY);
		rc(`OFF_LINKUP_CNT, 32'h000000FF, 32'h1, `RESP_OKAY);
	endtask

	// =============================================================
	// Main sequence and watchdog.
	initial begin
		errors = 0;
		comparisons = 0;
		i_rstn = 1'b0;
		mode = 3'h0;
		i_s_axi_awaddr = 8'h00;
		i_s_axi_araddr = 8'h00;
		i_s_axi_wdata = 32'h0;
		i_s_axi_wstrb = 4'hF;
		{i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h0;
		{i_s_axi_arvalid, i_s_axi_rready} = 2'h0;
		repeat (4) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		t_reset;
		t_pass;
		t_fail(3'h1, 32'h00000002, 0, 4000);
		t_fail(3'h2, 32'h00000002, 0, 4000);
		t_fail(3'h3, 32'h00000002, 0, 4000);
		t_fail(3'h4, 32'h00000003, 40, 48);
		t_clear;
		end_sim;
	end

	// A hang counts as a mismatch and ends the run the same way.
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		errors++;
		end_sim;
	end
endmodule
